// ===== core/hucp_consts.svh
// constants of the host serial command port
`ifndef HUCP_CONSTS_SVH
`define HUCP_CONSTS_SVH

`define HUCP_ADR_DATA   8'h00
`define HUCP_ADR_STATUS 8'h04
`define HUCP_ADR_CTRL   8'h08
`define HUCP_ADR_BAUD   8'h0C

`define HUCP_ST_RXV     0
`define HUCP_ST_TXRDY   1
`define HUCP_ST_TXBUSY  2
`define HUCP_ST_OVR     3
`define HUCP_ST_FERR    4
`define HUCP_ST_CTS     5

`define HUCP_CT_FLOW    0
`define HUCP_CT_UPLOAD  1
`define HUCP_FLOW_RST   1'b1
`define HUCP_UPLOAD_RST 1'b0

`define HUCP_CLK_HZ     64'd50000000
`define HUCP_BAUD_RST   64'd115200
`define HUCP_BAUD_MAX   64'd4000000
`define HUCP_ACC_ONE    64'd65536
// phase step per clock, rounded for the default, floored for the ceiling
`define HUCP_STEP_RST   16'((`HUCP_BAUD_RST*`HUCP_ACC_ONE \
                          +`HUCP_CLK_HZ/64'd2)/`HUCP_CLK_HZ)
`define HUCP_STEP_MAX   16'((`HUCP_BAUD_MAX*`HUCP_ACC_ONE)/`HUCP_CLK_HZ)
`define HUCP_ACC_HALF   16'h8000
`define HUCP_LAST_BIT   3'h7

`endif

// ===== core/hucp_pkg.sv
// types of the host serial command port
package hucp_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hucp_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hucp_rx_e;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        flow_en;
    logic        upload;
    logic [15:0] step;
    logic        ovr;
    logic        ferr;
    hucp_tx_e    tx_st;
    logic [15:0] tx_acc;
    logic [2:0]  tx_cnt;
    logic [7:0]  tx_sh;
    logic        txd;
    hucp_rx_e    rx_st;
    logic [15:0] rx_acc;
    logic [2:0]  rx_cnt;
    logic [7:0]  rx_sh;
  } hucp_state_s;

  typedef struct packed {
    logic       valid;
    logic       ready;
    logic [7:0] data;
  } hucp_stream_s;

endpackage : hucp_pkg

// ===== core/hucp_sync.sv
// two-flop synchroniser for one pin, idle level high
`timescale 1ns/1ps
module hucp_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } hucp_sync_s;

  hucp_sync_s s;
  hucp_sync_s next_s;

  always_comb begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{s1: 1'b1, s2: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;
endmodule : hucp_sync

// ===== core/hucp_fifo2.sv
// small fifo with valid and ready on both sides
`timescale 1ns/1ps
module hucp_fifo2 #(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0]       wp;
    logic [PW-1:0]       rp;
    logic [PW:0]         cnt;
  } hucp_fifo_s;

  hucp_fifo_s s;
  hucp_fifo_s next_s;
  logic       push;
  logic       pop;

  function automatic logic [PW-1:0] hucp_inc(input logic [PW-1:0] p);
    hucp_inc = (p == PW'(D - 1)) ? '0 : p + PW'(1);
  endfunction : hucp_inc

  assign in_ready_o  = (s.cnt != (PW+1)'(D));
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o  = s.mem[s.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp        = hucp_inc(s.wp);
    end
    if (pop) begin
      next_s.rp = hucp_inc(s.rp);
    end
    next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : hucp_fifo2

// ===== core/hucp_uart.sv
// host serial command port with wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "hucp_consts.svh"
module hucp_uart (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rxd_i,
  input  wire logic        cts_n_i,
  output logic             txd_o,
  output logic             rts_n_o,
  output logic             upload_o
);
  hucp_pkg::hucp_state_s  s;
  hucp_pkg::hucp_state_s  next_s;
  hucp_pkg::hucp_stream_s txf_in;
  hucp_pkg::hucp_stream_s txf_out;
  hucp_pkg::hucp_stream_s rxf_in;
  hucp_pkg::hucp_stream_s rxf_out;
  logic                   rxd_s;
  logic                   cts_n_s;
  logic                   cts_ok;
  logic                   req;
  logic                   wr_stall;
  logic [16:0]            tsum;
  logic [16:0]            rsum;
  logic                   ttick;
  logic                   rtick;
  logic [31:0]            status;
  logic                   tx_push;
  logic                   tx_pop;
  logic                   rx_push;
  logic                   rx_pop;

  function automatic logic hucp_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    hucp_hit = (a == off);
  endfunction : hucp_hit

  hucp_sync u_rx_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (rxd_i),
    .q_o   (rxd_s)
  );

  hucp_sync u_cts_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (cts_n_i),
    .q_o   (cts_n_s)
  );

  // a stalled transmitter fills this; writes to data then wait for ack
  hucp_fifo2 #(.W(8), .D(2)) u_tx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (txf_in.valid),
    .in_ready_o  (txf_in.ready),
    .in_data_i   (txf_in.data),
    .out_valid_o (txf_out.valid),
    .out_ready_i (txf_out.ready),
    .out_data_o  (txf_out.data)
  );

  hucp_fifo2 #(.W(8), .D(2)) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rxf_in.valid),
    .in_ready_o  (rxf_in.ready),
    .in_data_i   (rxf_in.data),
    .out_valid_o (rxf_out.valid),
    .out_ready_i (rxf_out.ready),
    .out_data_o  (rxf_out.data)
  );

  // in-side ready and out-side valid and data come from the fifos, the rest is driven here
  assign txf_in.valid  = tx_push;
  assign txf_in.data   = wb_dat_i[7:0];
  assign txf_out.ready = tx_pop;
  assign rxf_in.valid  = rx_push;
  assign rxf_in.data   = s.rx_sh;
  assign rxf_out.ready = rx_pop;

  assign cts_ok = ~s.flow_en | ~cts_n_s;
  assign tsum   = {1'b0, s.tx_acc} + {1'b0, s.step};
  assign rsum   = {1'b0, s.rx_acc} + {1'b0, s.step};
  assign ttick  = tsum[16];
  assign rtick  = rsum[16];
  assign req    = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr_stall = wb_we_i & hucp_hit(wb_adr_i, `HUCP_ADR_DATA)
                  & wb_sel_i[0] & ~txf_in.ready;

  always_comb begin
    status = '0;
    status[`HUCP_ST_RXV]    = rxf_out.valid;
    status[`HUCP_ST_TXRDY]  = txf_in.ready;
    status[`HUCP_ST_TXBUSY] = (s.tx_st != hucp_pkg::TX_IDLE);
    status[`HUCP_ST_OVR]    = s.ovr;
    status[`HUCP_ST_FERR]   = s.ferr;
    status[`HUCP_ST_CTS]    = ~cts_n_s;
  end

  // host writes and reads bytes of the command stream through data
  always_comb begin
    next_s        = s;
    next_s.ack    = 1'b0;
    tx_push       = 1'b0;
    rx_pop        = 1'b0;
    tx_pop        = 1'b0;
    rx_push       = 1'b0;
    if (req && !wr_stall) begin
      next_s.ack  = 1'b1;
      next_s.rdat = '0;
      if (wb_we_i) begin
        if (hucp_hit(wb_adr_i, `HUCP_ADR_DATA)) begin
          tx_push = wb_sel_i[0];
        end
        if (hucp_hit(wb_adr_i, `HUCP_ADR_STATUS) && wb_sel_i[0]) begin
          next_s.ovr  = s.ovr & ~wb_dat_i[`HUCP_ST_OVR];
          next_s.ferr = s.ferr & ~wb_dat_i[`HUCP_ST_FERR];
        end
        if (hucp_hit(wb_adr_i, `HUCP_ADR_CTRL) && wb_sel_i[0]) begin
          next_s.flow_en = wb_dat_i[`HUCP_CT_FLOW];
          next_s.upload  = wb_dat_i[`HUCP_CT_UPLOAD];
        end
        if (hucp_hit(wb_adr_i, `HUCP_ADR_BAUD)) begin
          if (wb_sel_i[0]) begin
            next_s.step[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_s.step[15:8] = wb_dat_i[15:8];
          end
          // faster than the ceiling would outrun the bit sampler
          if (next_s.step > `HUCP_STEP_MAX) begin
            next_s.step = `HUCP_STEP_MAX;
          end
          if (next_s.step == 16'h0000) begin
            next_s.step = 16'h0001;
          end
        end
      end else begin
        case (wb_adr_i)
          `HUCP_ADR_DATA: begin
            // an empty buffer reads zero rather than a stale slot
            if (rxf_out.valid) begin
              next_s.rdat = {24'h000000, rxf_out.data};
            end
            rx_pop = 1'b1;
          end
          `HUCP_ADR_STATUS: next_s.rdat = status;
          `HUCP_ADR_CTRL: begin
            next_s.rdat[`HUCP_CT_FLOW]   = s.flow_en;
            next_s.rdat[`HUCP_CT_UPLOAD] = s.upload;
          end
          `HUCP_ADR_BAUD: next_s.rdat = {16'h0000, s.step};
          default: next_s.rdat = '0;
        endcase
      end
    end

    // transmitter: start low, lsb first, stop high
    case (s.tx_st)
      hucp_pkg::TX_IDLE: begin
        next_s.txd = 1'b1;
        if (txf_out.valid && cts_ok) begin
          tx_pop        = 1'b1;
          next_s.tx_sh  = txf_out.data;
          next_s.tx_acc = '0;
          next_s.txd    = 1'b0;
          next_s.tx_st  = hucp_pkg::TX_START;
        end
      end
      hucp_pkg::TX_START: begin
        next_s.tx_acc = tsum[15:0];
        if (ttick) begin
          next_s.txd    = s.tx_sh[0];
          next_s.tx_cnt = '0;
          next_s.tx_st  = hucp_pkg::TX_DATA;
        end
      end
      hucp_pkg::TX_DATA: begin
        next_s.tx_acc = tsum[15:0];
        if (ttick) begin
          if (s.tx_cnt == `HUCP_LAST_BIT) begin
            next_s.txd   = 1'b1;
            next_s.tx_st = hucp_pkg::TX_STOP;
          end else begin
            next_s.tx_cnt = s.tx_cnt + 3'h1;
            next_s.tx_sh  = {1'b0, s.tx_sh[7:1]};
            next_s.txd    = s.tx_sh[1];
          end
        end
      end
      hucp_pkg::TX_STOP: begin
        next_s.tx_acc = tsum[15:0];
        if (ttick) begin
          next_s.tx_st = hucp_pkg::TX_IDLE;
        end
      end
      default: next_s.tx_st = hucp_pkg::TX_IDLE;
    endcase

    // receiver samples mid-bit: the phase starts half a bit ahead
    case (s.rx_st)
      hucp_pkg::RX_IDLE: begin
        if (!rxd_s) begin
          next_s.rx_acc = `HUCP_ACC_HALF;
          next_s.rx_st  = hucp_pkg::RX_START;
        end
      end
      hucp_pkg::RX_START: begin
        next_s.rx_acc = rsum[15:0];
        if (rtick) begin
          next_s.rx_cnt = '0;
          // a start bit that is gone at mid-bit was a glitch
          next_s.rx_st  = rxd_s ? hucp_pkg::RX_IDLE
                                : hucp_pkg::RX_DATA;
        end
      end
      hucp_pkg::RX_DATA: begin
        next_s.rx_acc = rsum[15:0];
        if (rtick) begin
          next_s.rx_sh = {rxd_s, s.rx_sh[7:1]};
          if (s.rx_cnt == `HUCP_LAST_BIT) begin
            next_s.rx_st = hucp_pkg::RX_STOP;
          end else begin
            next_s.rx_cnt = s.rx_cnt + 3'h1;
          end
        end
      end
      hucp_pkg::RX_STOP: begin
        next_s.rx_acc = rsum[15:0];
        if (rtick) begin
          next_s.rx_st = hucp_pkg::RX_IDLE;
          rx_push      = rxd_s;
          // set wins over a clear in the same cycle
          if (rxd_s && !rxf_in.ready) begin
            next_s.ovr = 1'b1;
          end
          if (!rxd_s) begin
            next_s.ferr = 1'b1;
          end
        end
      end
      default: next_s.rx_st = hucp_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.flow_en <= `HUCP_FLOW_RST;
      s.upload  <= `HUCP_UPLOAD_RST;
      s.step    <= `HUCP_STEP_RST;
      s.txd     <= 1'b1;
      s.tx_st   <= hucp_pkg::TX_IDLE;
      s.rx_st   <= hucp_pkg::RX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // one byte of slack: flow goes off while a byte waits, the second
  // slot takes the byte the host may already have started
  assign rts_n_o  = s.flow_en & rxf_out.valid;
  assign txd_o    = s.txd;
  assign upload_o = s.upload;
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_wr;
    req && !wr_stall && wb_we_i && wb_sel_i[0]
      && hucp_hit(wb_adr_i, `HUCP_ADR_CTRL);
  endsequence

  sequence s_tx_launch;
    s.tx_st == hucp_pkg::TX_IDLE && txf_out.valid && cts_ok;
  endsequence

  a_rts_flow_off: assert property (
    s.flow_en && rxf_in.valid && rxf_in.ready && !(req && wb_we_i)
      |=> rts_n_o)
    else $error("rts not raised after a byte was buffered");
  a_tx_cts_gate: assert property (
    s.tx_st == hucp_pkg::TX_IDLE && s.flow_en && cts_n_s
      |=> s.tx_st == hucp_pkg::TX_IDLE)
    else $error("transmit started without clear to send");
  a_step_ceiling: assert property (
    s.step <= `HUCP_STEP_MAX && s.step != 16'h0000)
    else $error("baud step outside allowed range");
  a_reset_defaults: assert property (
    $past(rst_i) |-> s.step == `HUCP_STEP_RST && s.flow_en && !s.upload)
    else $error("wrong defaults after reset");
  a_upload_ctrl: assert property (
    s_ctrl_wr |=> upload_o == $past(wb_dat_i[`HUCP_CT_UPLOAD]))
    else $error("upload flag not taken from control write");
  a_start_low: assert property (
    s_tx_launch |=> !txd_o && s.tx_st == hucp_pkg::TX_START)
    else $error("start bit not low");
  a_stop_idle: assert property (
    s.tx_st == hucp_pkg::TX_STOP || s.tx_st == hucp_pkg::TX_IDLE
      |-> txd_o)
    else $error("line not high in stop or idle");
  a_rx_push: assert property (
    s.rx_st == hucp_pkg::RX_STOP && rtick && rxd_s && rxf_in.ready
      |=> rxf_out.valid)
    else $error("received byte not buffered");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : hucp_uart

// ===== testbench/hucp_host.sv
// far-side host model: sends and receives 8N1 characters with flow control
`timescale 1ns/1ps
module hucp_host (
  input  wire logic txd_i,
  input  wire logic rts_n_i,
  input  wire logic prog_i,
  output logic      rxd_o,
  output logic      cts_n_o
);
  // bit time of the host clock; rounded to whole ns, well inside the 1% margin
  real        bit_ns = 8680.0;
  logic       hold   = 1'b0;
  logic [7:0] got[$];
  logic [7:0] sh;

  // in upload mode the host sits in reset: its pins float to the pull-up
  assign cts_n_o = hold | prog_i;

  initial rxd_o = 1'b1;

  task automatic send(input logic [7:0] b, input logic stop);
    wait (rts_n_i === 1'b0 && prog_i === 1'b0);
    rxd_o = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      rxd_o = b[i];
      #(bit_ns);
    end
    rxd_o = stop;
    #(bit_ns);
    rxd_o = 1'b1;
  endtask : send

  // sample each bit in its middle; a low stop bit drops the character
  always begin
    @(negedge txd_i);
    #(bit_ns * 1.5);
    for (int i = 0; i < 8; i++) begin
      sh[i] = txd_i;
      #(bit_ns);
    end
    if (txd_i === 1'b1) got.push_back(sh);
  end
endmodule : hucp_host

// ===== testbench/tb_hucp_uart.sv
// self-checking testbench of the host serial command port
`timescale 1ns/1ps
`include "hucp_consts.svh"
module tb_hucp_uart;
  typedef struct packed {
    logic        we;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] x;
    logic        up;
  } hucp_row_s;

  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic        wb_we_i  = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        rxd_i;
  logic        cts_n_i;
  logic        txd_o;
  logic        rts_n_o;
  logic        upload_o;
  logic [31:0] q;
  logic [7:0]  tx_exp[3] = '{8'h5A, 8'hA5, 8'h0F};
  int          mismatches = 0;
  int          tests_run  = 0;
  hucp_row_s   rows[14] = '{
    '{1'b0, `HUCP_ADR_CTRL,   32'h0,    32'h1,    1'b0},
    '{1'b0, `HUCP_ADR_BAUD,   32'h0,    32'h97,   1'b0},
    '{1'b0, `HUCP_ADR_STATUS, 32'h0,    32'h22,   1'b0},
    '{1'b1, 8'h10,            32'hFF,   32'h0,    1'b0},
    '{1'b0, 8'h10,            32'h0,    32'h0,    1'b0},
    '{1'b1, `HUCP_ADR_BAUD,   32'hFFFF, 32'h0,    1'b0},
    '{1'b0, `HUCP_ADR_BAUD,   32'h0,    32'h147A, 1'b0},
    '{1'b1, `HUCP_ADR_BAUD,   32'h0,    32'h0,    1'b0},
    '{1'b0, `HUCP_ADR_BAUD,   32'h0,    32'h1,    1'b0},
    '{1'b1, `HUCP_ADR_CTRL,   32'h3,    32'h0,    1'b1},
    '{1'b0, `HUCP_ADR_CTRL,   32'h0,    32'h3,    1'b1},
    '{1'b0, `HUCP_ADR_STATUS, 32'h0,    32'h2,    1'b1},
    '{1'b1, `HUCP_ADR_CTRL,   32'h1,    32'h0,    1'b0},
    '{1'b1, `HUCP_ADR_BAUD,   32'h147A, 32'h0,    1'b0}};

  always #10 clk_i = ~clk_i;

  hucp_uart u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rxd_i(rxd_i), .cts_n_i(cts_n_i), .txd_o(txd_o), .rts_n_o(rts_n_o),
    .upload_o(upload_o));

  hucp_host u_host (
    .txd_i(txd_o), .rts_n_i(rts_n_o), .prog_i(upload_o), .rxd_o(rxd_i),
    .cts_n_o(cts_n_i));

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // classic cycle; no fixed latency assumed, the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wait_rx(input int n);
    while (u_host.got.size() < n) begin
      @(posedge clk_i);
    end
  endtask : wait_rx

  task automatic give_verdict;
    $display("counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    // the slow character at the reset rate dominates: about 105 us
    #400000;
    mismatches++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    give_verdict();
  end

  initial begin
    // rst_i is the pin reset after its long low hold is stretched
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].a, rows[i].d, q);
      if (!rows[i].we) chk_word(q, rows[i].x);
      chk_bit(upload_o, rows[i].up);
    end
    $display("test registers done");
    u_host.bit_ns = 250.0;
    u_host.send(8'h3C, 1'b1);
    chk_bit(rts_n_o, 1'b1);
    wb(1'b0, `HUCP_ADR_DATA, 32'h0, q);
    chk_word(q, 32'h3C);
    chk_bit(rts_n_o, 1'b0);
    wb(1'b0, `HUCP_ADR_DATA, 32'h0, q);
    chk_word(q, 32'h0);
    $display("test receive done");
    // flow off: nothing throttles the host, the third byte overruns
    wb(1'b1, `HUCP_ADR_CTRL, 32'h0, q);
    for (int i = 0; i < 3; i++) u_host.send(8'h81 + 8'(i), 1'b1);
    wb(1'b0, `HUCP_ADR_STATUS, 32'h0, q);
    chk_word(q, 32'h2B);
    wb(1'b0, `HUCP_ADR_DATA, 32'h0, q);
    chk_word(q, 32'h81);
    wb(1'b0, `HUCP_ADR_DATA, 32'h0, q);
    chk_word(q, 32'h82);
    wb(1'b0, `HUCP_ADR_DATA, 32'h0, q);
    chk_word(q, 32'h0);
    u_host.send(8'hFF, 1'b0);
    wb(1'b0, `HUCP_ADR_STATUS, 32'h0, q);
    chk_word(q, 32'h3A);
    wb(1'b1, `HUCP_ADR_STATUS, 32'h18, q);
    wb(1'b0, `HUCP_ADR_STATUS, 32'h0, q);
    chk_word(q, 32'h22);
    wb(1'b1, `HUCP_ADR_CTRL, 32'h1, q);
    $display("test errors done");
    // host stalls: buffer fills, line stays idle, then drains in order
    u_host.hold <= 1'b1;
    wb(1'b1, `HUCP_ADR_DATA, 32'h5A, q);
    wb(1'b1, `HUCP_ADR_DATA, 32'hA5, q);
    repeat (40) @(posedge clk_i);
    wb(1'b0, `HUCP_ADR_STATUS, 32'h0, q);
    chk_word(q, 32'h0);
    chk_bit(txd_o, 1'b1);
    u_host.hold <= 1'b0;
    wb(1'b1, `HUCP_ADR_DATA, 32'h0F, q);
    wait_rx(3);
    foreach (tx_exp[i]) begin
      chk_word({24'h0, u_host.got[i]}, {24'h0, tx_exp[i]});
    end
    $display("test stall done");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(txd_o, 1'b1);
    chk_bit(rts_n_o, 1'b0);
    chk_bit(upload_o, 1'b0);
    wb(1'b0, `HUCP_ADR_BAUD, 32'h0, q);
    chk_word(q, 32'h97);
    u_host.bit_ns = 8680.0;
    wb(1'b1, `HUCP_ADR_DATA, 32'hC6, q);
    wb(1'b0, `HUCP_ADR_STATUS, 32'h0, q);
    chk_word(q, 32'h26);
    wait_rx(4);
    chk_word({24'h0, u_host.got[3]}, 32'hC6);
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_hucp_uart
